// ### verilog/ppe_cfg.svh
`ifndef PPE_CFG_SVH
`define PPE_CFG_SVH

// ==========================================================
// Clock
`define PPE_CLK_PERIOD_NS     10

// ==========================================================
// Register offsets within the addressed page
`define PPE_OFS_PAGE          8'h00
`define PPE_OFS_STAT_A        8'h50
`define PPE_OFS_STAT_B        8'h51
`define PPE_OFS_EVT_A         8'h52
`define PPE_OFS_EVT_B         8'h53
`define PPE_OFS_MASK_A        8'h54
`define PPE_OFS_MASK_B        8'h55
`define PPE_OFS_CTRL          8'h56

// ==========================================================
// Field positions
`define PPE_BIT_AUTO_RET      7
`define PPE_BIT_WMODE         6
`define PPE_BIT_LOCK          7
`define PPE_BIT_OVL_B         5
`define PPE_BIT_OVL_A         4

// ==========================================================
// Reset values and writable bits
`define PPE_RST_PAGE          8'h00
`define PPE_RST_MASK_A        8'h00
`define PPE_RST_MASK_B        8'h00
`define PPE_RST_CTRL          8'h00
`define PPE_WMASK_PAGE        8'hC7
`define PPE_WMASK_EVT_A       8'h5F
`define PPE_WMASK_EVT_B       8'h3F

// ==========================================================
// Locked configuration window, full addresses
`define PPE_LOCK_LO           10'h0D0
`define PPE_LOCK_HI           10'h14F

// ==========================================================
// Voltage step intervals in ns, codes 00 to 11
`define PPE_STEP_T0_NS        4000
`define PPE_STEP_T1_NS        2000
`define PPE_STEP_T2_NS        1000
`define PPE_STEP_T3_NS        500
`define PPE_STEP_CNT_W        9

// ==========================================================
// Debounce times in us, codes 001 to 111
`define PPE_DEB_T1_US         100
`define PPE_DEB_T2_US         1000
`define PPE_DEB_T3_US         10000
`define PPE_DEB_T4_US         50000
`define PPE_DEB_T5_US         250000
`define PPE_DEB_T6_US         500000
`define PPE_DEB_T7_US         1000000
`define PPE_DEB_CNT_W         27

// ==========================================================
// Synchronised input vector width
`define PPE_SYNC_W            14

`endif

// ### verilog/ppe_pkg.sv
`include "ppe_cfg.svh"

package ppe_pkg;

  // Debouncer state
  typedef struct packed {
    logic                         level;
    logic [`PPE_DEB_CNT_W-1:0]    cnt;
  } ppe_deb_t;

  // Sticky event bank state
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] held;
  } ppe_evt_t;

  // Register block state
  typedef struct packed {
    logic [7:0]                   page;
    logic [7:0]                   mask_a;
    logic [7:0]                   mask_b;
    logic [7:0]                   ctrl;
    logic [`PPE_SYNC_W-1:0]       s1;
    logic [`PPE_SYNC_W-1:0]       s2;
    logic [`PPE_SYNC_W-1:0]       s3;
    logic [`PPE_SYNC_W-1:0]       lvl;
    logic [4:0]                   deb_prev;
    logic [8:0]                   mon_prev;
    logic                         st_req;
    logic                         st_we;
    logic                         st_ok;
    logic [9:0]                   st_addr;
    logic [7:0]                   st_wdata;
    logic                         ext_wr;
    logic                         ext_rd;
    logic [7:0]                   rdata;
    logic                         rvalid;
    logic                         repeat_write;
    logic [`PPE_STEP_CNT_W-1:0]   step_cnt_a;
    logic [`PPE_STEP_CNT_W-1:0]   step_cnt_b;
    logic                         step_a;
    logic                         step_b;
  } ppe_state_t;

endpackage

// ### verilog/ppe_debounce.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppe_cfg.svh"

module ppe_debounce (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      raw_i,
  input  wire logic                      enable_i,
  input  wire logic [`PPE_DEB_CNT_W-1:0] limit_i,
  output logic                           level_o
);

  ppe_pkg::ppe_deb_t s;
  ppe_pkg::ppe_deb_t next_s;

  // ==========================================================
  // Level follows input once stable for limit plus one cycles
  always_comb begin
    next_s = s;
    if (raw_i == s.level) begin
      next_s.cnt = '0;
    end else if (!enable_i || s.cnt >= limit_i) begin
      next_s.level = raw_i;
      next_s.cnt   = '0;
    end else begin
      next_s.cnt = s.cnt + `PPE_DEB_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_o = s.level;

endmodule
`default_nettype wire

// ### verilog/ppe_event_bank.sv
`timescale 1ns/100ps
`default_nettype none

module ppe_event_bank (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] set_i,
  input  wire logic       clr_wr_i,
  input  wire logic [7:0] clr_data_i,
  output logic [7:0]      flags_o
);

  ppe_pkg::ppe_evt_t s;
  ppe_pkg::ppe_evt_t next_s;

  // ==========================================================
  // Clear by written ones; events during a clear wait a cycle
  always_comb begin
    next_s = s;
    if (clr_wr_i) begin
      next_s.flags = s.flags & ~clr_data_i;
      next_s.held  = s.held | set_i;
    end else begin
      next_s.flags = s.flags | set_i | s.held;
      next_s.held  = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign flags_o = s.flags;

endmodule
`default_nettype wire

// ### verilog/ppe_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ppe_cfg.svh"

module ppe_regs #(
  parameter int DEB_CYC_1 = `PPE_DEB_T1_US * 1000 / `PPE_CLK_PERIOD_NS,
  parameter int DEB_CYC_2 = `PPE_DEB_T2_US * 1000 / `PPE_CLK_PERIOD_NS,
  parameter int DEB_CYC_3 = `PPE_DEB_T3_US * 1000 / `PPE_CLK_PERIOD_NS,
  parameter int DEB_CYC_4 = `PPE_DEB_T4_US * 1000 / `PPE_CLK_PERIOD_NS,
  parameter int DEB_CYC_5 = `PPE_DEB_T5_US * 1000 / `PPE_CLK_PERIOD_NS,
  parameter int DEB_CYC_6 = `PPE_DEB_T6_US * 1000 / `PPE_CLK_PERIOD_NS,
  parameter int DEB_CYC_7 = `PPE_DEB_T7_US * 1000 / `PPE_CLK_PERIOD_NS
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       four_wire_i,
  input  wire logic       acc_req_i,
  input  wire logic       acc_we_i,
  input  wire logic [7:0] acc_addr_i,
  input  wire logic [7:0] acc_wdata_i,
  input  wire logic       acc_end_i,
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  output logic [9:0]      ext_addr_o,
  output logic [7:0]      ext_wdata_o,
  output logic            ext_wr_o,
  output logic            ext_rd_o,
  input  wire logic [7:0] ext_rdata_i,
  output logic            repeat_write_o,
  input  wire logic [4:0] general_input_i,
  input  wire logic [4:0] input_active_high_i,
  input  wire logic [4:0] input_debounce_en_i,
  input  wire logic       io_supply_undervoltage_i,
  input  wire logic       rail_a_ramping_i,
  input  wire logic       rail_b_ramping_i,
  input  wire logic       rail_a_current_limit_i,
  input  wire logic       rail_b_current_limit_i,
  input  wire logic       thermal_shutdown_flag_i,
  input  wire logic       thermal_warning_flag_i,
  input  wire logic       rail_a_in_range_i,
  input  wire logic       rail_b_in_range_i,
  output logic            rail_a_step_o,
  output logic            rail_b_step_o,
  output logic            interrupt_out_n_o
);

  // ==========================================================
  // Helpers

  localparam int STEP_CYC_0 = `PPE_STEP_T0_NS / `PPE_CLK_PERIOD_NS;
  localparam int STEP_CYC_1 = `PPE_STEP_T1_NS / `PPE_CLK_PERIOD_NS;
  localparam int STEP_CYC_2 = `PPE_STEP_T2_NS / `PPE_CLK_PERIOD_NS;
  localparam int STEP_CYC_3 = `PPE_STEP_T3_NS / `PPE_CLK_PERIOD_NS;

  // Step interval in cycles, minus one, for a rate code
  function automatic logic [`PPE_STEP_CNT_W-1:0] step_last(input logic [1:0] code);
    logic [`PPE_STEP_CNT_W-1:0] r;
    unique case (code)
      2'b00: r = `PPE_STEP_CNT_W'(STEP_CYC_0 - 1);
      2'b01: r = `PPE_STEP_CNT_W'(STEP_CYC_1 - 1);
      2'b10: r = `PPE_STEP_CNT_W'(STEP_CYC_2 - 1);
      2'b11: r = `PPE_STEP_CNT_W'(STEP_CYC_3 - 1);
    endcase
    return r;
  endfunction

  // Page plus offset to {valid, full address}
  function automatic logic [10:0] map_addr(input logic [2:0] pg, input logic fw, input logic [7:0] a);
    logic [10:0] r;
    r = '0;
    if (!fw) begin
      unique case (pg[2:1])
        2'b00: r = {1'b1, 2'b00, a};
        2'b01: r = {~a[7], 3'b010, a[6:0]};
        2'b10: r = {~a[7], 3'b100, a[6:0]};
        2'b11: r = '0;
      endcase
    end else begin
      case (pg)
        3'b000:  r = {~a[7], 3'b000, a[6:0]};
        3'b001:  r = {~a[7], 3'b001, a[6:0]};
        3'b010:  r = {~a[7], 3'b010, a[6:0]};
        3'b100:  r = {~a[7], 3'b100, a[6:0]};
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  ppe_pkg::ppe_state_t s;
  ppe_pkg::ppe_state_t next_s;

  // ==========================================================
  // Input debouncing and event banks

  logic [4:0]                 deb_lvl;
  logic [`PPE_DEB_CNT_W-1:0]  deb_limit;
  logic [7:0]                 evt_a;
  logic [7:0]                 evt_b;
  logic [7:0]                 set_a;
  logic [7:0]                 set_b;
  logic                       clr_a;
  logic                       clr_b;

  // Debounce time from control field
  always_comb begin
    unique case (s.ctrl[2:0])
      3'b000: deb_limit = '0;
      3'b001: deb_limit = `PPE_DEB_CNT_W'(DEB_CYC_1);
      3'b010: deb_limit = `PPE_DEB_CNT_W'(DEB_CYC_2);
      3'b011: deb_limit = `PPE_DEB_CNT_W'(DEB_CYC_3);
      3'b100: deb_limit = `PPE_DEB_CNT_W'(DEB_CYC_4);
      3'b101: deb_limit = `PPE_DEB_CNT_W'(DEB_CYC_5);
      3'b110: deb_limit = `PPE_DEB_CNT_W'(DEB_CYC_6);
      3'b111: deb_limit = `PPE_DEB_CNT_W'(DEB_CYC_7);
    endcase
  end

  // One debouncer per general input
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_deb
      ppe_debounce u_deb (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .raw_i    (s.lvl[gi]),
        .enable_i (input_debounce_en_i[gi] && (s.ctrl[2:0] != 3'h0)),
        .limit_i  (deb_limit),
        .level_o  (deb_lvl[gi])
      );
    end
  endgenerate

  // Event sources from accepted levels
  logic [4:0] act_now;
  logic [4:0] act_prev;
  logic [8:0] mon_now;
  logic [8:0] mon_rise;
  logic [8:0] mon_fall;

  always_comb begin
    act_now  = deb_lvl ^ ~input_active_high_i;
    act_prev = s.deb_prev ^ ~input_active_high_i;
    mon_now  = s.lvl[13:5];
    mon_rise = mon_now & ~s.mon_prev;
    mon_fall = ~mon_now & s.mon_prev;
    set_a    = {1'b0, mon_rise[0], 1'b0, act_now & ~act_prev};
    set_b    = {2'b00,
                mon_rise[4] & ~s.mask_b[`PPE_BIT_OVL_B],
                mon_rise[3] & ~s.mask_b[`PPE_BIT_OVL_A],
                mon_rise[5], mon_rise[6],
                mon_fall[8], mon_fall[7]};
    clr_a    = s.st_req && s.st_we && s.st_ok && s.st_addr == {2'b00, `PPE_OFS_EVT_A};
    clr_b    = s.st_req && s.st_we && s.st_ok && s.st_addr == {2'b00, `PPE_OFS_EVT_B};
  end

  ppe_event_bank u_evt_a (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .set_i      (set_a),
    .clr_wr_i   (clr_a),
    .clr_data_i (s.st_wdata & `PPE_WMASK_EVT_A),
    .flags_o    (evt_a)
  );

  ppe_event_bank u_evt_b (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .set_i      (set_b),
    .clr_wr_i   (clr_b),
    .clr_data_i (s.st_wdata & `PPE_WMASK_EVT_B),
    .flags_o    (evt_b)
  );

  // ==========================================================
  // Status views and register decode

  logic [7:0]  stat_a;
  logic [7:0]  stat_b;
  logic [10:0] map;
  logic        own_page;
  logic        own_p0;
  logic        locked;
  logic [7:0]  rd_mux;

  always_comb begin
    stat_a   = {3'b000, deb_lvl};
    stat_b   = {~s.lvl[7], ~s.lvl[6],
                s.lvl[9], s.lvl[8],
                s.lvl[10], s.lvl[11],
                s.lvl[13], s.lvl[12]};
    map      = map_addr(s.page[2:0], four_wire_i, acc_addr_i);
    own_page = s.st_addr[6:0] == 7'h00 && s.st_addr[7] == (four_wire_i && s.st_addr[9:8] == 2'b00 && s.page[0]);
    own_p0   = s.st_addr[9:8] == 2'b00 && s.st_addr[7:3] == 5'h0A && s.st_addr[2:0] != 3'h7;
    locked   = s.ctrl[`PPE_BIT_LOCK] && s.st_addr >= `PPE_LOCK_LO && s.st_addr <= `PPE_LOCK_HI;
    rd_mux   = ext_rdata_i;
    if (own_page) begin
      rd_mux = s.page & `PPE_WMASK_PAGE;
    end else if (own_p0) begin
      unique case (s.st_addr[2:0])
        3'h0: rd_mux = stat_a;
        3'h1: rd_mux = stat_b;
        3'h2: rd_mux = evt_a;
        3'h3: rd_mux = evt_b;
        3'h4: rd_mux = s.mask_a;
        3'h5: rd_mux = s.mask_b;
        3'h6: rd_mux = s.ctrl;
        3'h7: rd_mux = '0;
      endcase
    end
  end

  // ==========================================================
  // Next state

  always_comb begin
    next_s = s;
    // Three-stage sampling, accepted when stages two and three agree
    next_s.s1  = {rail_b_in_range_i, rail_a_in_range_i, thermal_warning_flag_i, thermal_shutdown_flag_i,
                  rail_b_current_limit_i, rail_a_current_limit_i, rail_b_ramping_i, rail_a_ramping_i,
                  io_supply_undervoltage_i, general_input_i};
    next_s.s2  = s.s1;
    next_s.s3  = s.s2;
    next_s.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 | s.s3));
    next_s.deb_prev = deb_lvl;
    next_s.mon_prev = mon_now;

    // Stage one: latch the decoded request
    next_s.st_req   = acc_req_i;
    next_s.st_we    = acc_we_i;
    next_s.st_ok    = map[10];
    next_s.st_addr  = map[9:0];
    next_s.st_wdata = acc_wdata_i;

    // Stage two: act on it
    next_s.ext_wr = 1'b0;
    next_s.ext_rd = 1'b0;
    next_s.rvalid = 1'b0;
    if (acc_req_i && map[10]) begin
      next_s.ext_rd = !acc_we_i;
    end
    if (s.st_req) begin
      next_s.rvalid = !s.st_we;
      next_s.rdata  = s.st_ok ? rd_mux : 8'h00;
      if (s.st_we && s.st_ok) begin
        if (own_page) begin
          next_s.page = s.st_wdata & `PPE_WMASK_PAGE;
        end else if (own_p0) begin
          unique case (s.st_addr[2:0])
            3'h4: next_s.mask_a = s.st_wdata & `PPE_WMASK_EVT_A;
            3'h5: next_s.mask_b = s.st_wdata & `PPE_WMASK_EVT_B;
            3'h6: next_s.ctrl   = s.st_wdata;
            default: next_s.ctrl = s.ctrl;                   // Offsets 0 to 3: no register change here; writes to 2 and 3 clear events via clr_a/clr_b
          endcase
        end else if (!locked) begin
          next_s.ext_wr = 1'b1;
        end
      end
    end

    // Page field returns to zero after the access
    if (acc_end_i && s.page[`PPE_BIT_AUTO_RET]) begin
      next_s.page[2:0] = 3'b000;
    end

    // Multi-byte write mode seen only by the two-wire engine
    next_s.repeat_write = !four_wire_i && next_s.page[`PPE_BIT_WMODE];

    // Voltage step timers per rail
    next_s.step_a = 1'b0;
    next_s.step_b = 1'b0;
    if (s.step_cnt_a >= step_last(s.ctrl[4:3])) begin
      next_s.step_cnt_a = '0;
      next_s.step_a     = 1'b1;
    end else begin
      next_s.step_cnt_a = s.step_cnt_a + `PPE_STEP_CNT_W'(1);
    end
    if (s.step_cnt_b >= step_last(s.ctrl[6:5])) begin
      next_s.step_cnt_b = '0;
      next_s.step_b     = 1'b1;
    end else begin
      next_s.step_cnt_b = s.step_cnt_b + `PPE_STEP_CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s        <= '0;
      s.page   <= `PPE_RST_PAGE;
      s.mask_a <= `PPE_RST_MASK_A;
      s.mask_b <= `PPE_RST_MASK_B;
      s.ctrl   <= `PPE_RST_CTRL;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs

  // External strobe follows stage-one address and data
  assign ext_addr_o     = s.st_addr;
  assign ext_wdata_o    = s.st_wdata;
  assign ext_wr_o       = s.ext_wr;
  assign ext_rd_o       = s.st_req && !s.st_we && s.st_ok && !own_page && !own_p0;
  assign rdata_o        = s.rdata;
  assign rvalid_o       = s.rvalid;
  assign repeat_write_o = s.repeat_write;
  assign rail_a_step_o  = s.step_a;
  assign rail_b_step_o  = s.step_b;

  // Active-low interrupt from unmasked sticky events
  assign interrupt_out_n_o = !(|(evt_a & ~s.mask_a) || |(evt_b & ~s.mask_b));

endmodule
`default_nettype wire

// ### bench/ppe_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Outside register file behind the block
module ppe_ext_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [9:0] ext_addr_i,
  input  wire logic [7:0] ext_wdata_i,
  input  wire logic       ext_wr_i,
  input  wire logic       ext_rd_i,
  output logic      [7:0] ext_rdata_o,
  output logic      [9:0] last_addr_o,
  output logic      [7:0] wr_cnt_o
);
  logic [7:0] mem [16];
  logic [7:0] last_q;
  // Data only while strobed, inverted last value otherwise
  assign ext_rdata_o = ext_rd_i ? mem[ext_addr_i[3:0]] : ~last_q;
  // Store writes, note address and count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_cnt_o    <= 8'h00;
      last_addr_o <= 10'h000;
      last_q      <= 8'h00;
    end else begin
      if (ext_wr_i) begin
        mem[ext_addr_i[3:0]] <= ext_wdata_i;
        last_addr_o          <= ext_addr_i;
        wr_cnt_o             <= wr_cnt_o + 8'h01;
      end
      if (ext_rd_i) begin
        last_q <= ext_rdata_o;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/ppe_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Port timing checks
module ppe_regs_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic four_wire_i,
  input wire logic acc_req_i,
  input wire logic acc_we_i,
  input wire logic rvalid_o,
  input wire logic ext_wr_o,
  input wire logic ext_rd_o,
  input wire logic repeat_write_o,
  input wire logic rail_a_step_o,
  input wire logic rail_b_step_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request kinds
  sequence s_rd;
    acc_req_i && !acc_we_i;
  endsequence
  sequence s_wr;
    acc_req_i && acc_we_i;
  endsequence
  a_read_two_cycles: assert property (s_rd |-> ##2 rvalid_o) else $error("read answer missing");
  a_write_no_answer: assert property (s_wr |-> ##2 !rvalid_o) else $error("write gave read data");
  a_answer_has_cause: assert property (rvalid_o |-> $past(acc_req_i, 2) && !$past(acc_we_i, 2))
    else $error("read data without read");
  a_ext_read_cause: assert property (ext_rd_o |-> $past(acc_req_i) && !$past(acc_we_i))
    else $error("outside read without read");
  a_ext_write_cause: assert property (ext_wr_o |-> $past(acc_req_i, 2) && $past(acc_we_i, 2))
    else $error("outside write without write");
  a_read_no_write: assert property (s_rd |-> ##2 !ext_wr_o) else $error("read caused write");
  a_four_wire_mode: assert property (four_wire_i && $past(four_wire_i) |-> !repeat_write_o)
    else $error("repeat mode on four-wire");
  a_step_a_gap: assert property (rail_a_step_o |=> !rail_a_step_o [*8]) else $error("step A too fast");
  a_step_b_gap: assert property (rail_b_step_o |=> !rail_b_step_o [*8]) else $error("step B too fast");
  a_step_b_due: assert property (rail_b_step_o |-> ##[1:512] rail_b_step_o) else $error("step B late");
endmodule

bind ppe_regs ppe_regs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .four_wire_i(four_wire_i),
  .acc_req_i(acc_req_i), .acc_we_i(acc_we_i), .rvalid_o(rvalid_o), .ext_wr_o(ext_wr_o),
  .ext_rd_o(ext_rd_o), .repeat_write_o(repeat_write_o), .rail_a_step_o(rail_a_step_o),
  .rail_b_step_o(rail_b_step_o));
`default_nettype wire

// ### bench/ppe_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module ppe_regs_test;
  logic       clk_i, rst_i, four_wire_i, acc_req_i, acc_we_i, acc_end_i, rvalid_o, ext_wr_o, ext_rd_o;
  logic       repeat_write_o, uv, rp_a, rp_b, cl_a, cl_b, tsd, twn, rg_a, rg_b, st_a, st_b, irq_n, rv;
  logic [7:0] acc_addr_i, acc_wdata_i, rdata_o, ext_wdata_o, ext_rdata_i, wr_cnt, c;
  logic [9:0] ext_addr_o, last_addr;
  logic [4:0] gi, act_hi, deb_en;
  int         n_errors, total_checks, cycles, gap_n;
  logic [27:0] t [10] = '{28'h0005005, 28'h0185085, 28'h0205105, 28'h0305105, 28'h0405205,
                          28'h0505205, 28'h1005005, 28'h1105085, 28'h1205105, 28'h1405205};
  ppe_regs #(.DEB_CYC_1(4), .DEB_CYC_2(8), .DEB_CYC_3(12), .DEB_CYC_4(16), .DEB_CYC_5(20),
    .DEB_CYC_6(24), .DEB_CYC_7(28)) dut (.clk_i(clk_i), .rst_i(rst_i), .four_wire_i(four_wire_i),
    .acc_req_i(acc_req_i), .acc_we_i(acc_we_i), .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_end_i(acc_end_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .ext_addr_o(ext_addr_o),
    .ext_wdata_o(ext_wdata_o), .ext_wr_o(ext_wr_o), .ext_rd_o(ext_rd_o), .ext_rdata_i(ext_rdata_i),
    .repeat_write_o(repeat_write_o), .general_input_i(gi), .input_active_high_i(act_hi),
    .input_debounce_en_i(deb_en), .io_supply_undervoltage_i(uv), .rail_a_ramping_i(rp_a),
    .rail_b_ramping_i(rp_b), .rail_a_current_limit_i(cl_a), .rail_b_current_limit_i(cl_b),
    .thermal_shutdown_flag_i(tsd), .thermal_warning_flag_i(twn), .rail_a_in_range_i(rg_a),
    .rail_b_in_range_i(rg_b), .rail_a_step_o(st_a), .rail_b_step_o(st_b), .interrupt_out_n_o(irq_n));
  ppe_ext_model u_ext (.clk_i(clk_i), .rst_i(rst_i), .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o),
    .ext_wr_i(ext_wr_o), .ext_rd_i(ext_rd_o), .ext_rdata_o(ext_rdata_i), .last_addr_o(last_addr),
    .wr_cnt_o(wr_cnt));
  // ==========================================================
  // Clock and hang limit
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  // ==========================================================
  // Access tasks
  task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    acc_req_i   = 1'b1;
    acc_we_i    = we;
    acc_addr_i  = a;
    acc_wdata_i = d;
    @(negedge clk_i);
    acc_req_i = 1'b0;
    // Read answer stands between the second and third edge
    @(negedge clk_i);
    rv = rvalid_o;
    // Outside write lands at the third edge
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK("rvalid", 1'b1, rv)
    `CHK("rdata", e, rdata_o)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Cycles between two step ticks of one rail
  task automatic gap(input logic b, output int n);
    n = 0;
    while ((b ? st_b : st_a) !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    while ((b ? st_b : st_a) !== 1'b1) begin
      n++;
      @(negedge clk_i);
    end
    n++;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {four_wire_i, acc_req_i, acc_we_i, acc_end_i, acc_addr_i, acc_wdata_i} = '0;
    {uv, rp_a, rp_b, cl_a, cl_b, tsd, twn} = '0;
    {rg_a, rg_b} = 2'b11;
    gi     = 5'h02;
    act_hi = 5'h1D;
    deb_en = 5'h04;
    rst_i  = 1'b1;
    cyc(12);
    rst_i = 1'b0;
    cyc(20);
    rd(8'h54, 8'h00);
    rd(8'h56, 8'h00);
    rd(8'h51, 8'hC3);
    acc(1'b1, 8'h51, 8'h00);
    rd(8'h51, 8'hC3);
    rd(8'h53, 8'h00);
    $display("test reset done");
    acc(1'b1, 8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    @(negedge clk_i) acc_end_i = 1'b1;
    @(negedge clk_i) acc_end_i = 1'b0;
    cyc(2);
    `CHK("repeat", 1'b1, repeat_write_o)
    rd(8'h00, 8'hC0);
    four_wire_i = 1'b1;
    cyc(2);
    `CHK("repeat", 1'b0, repeat_write_o)
    acc(1'b1, 8'h00, 8'h00);
    four_wire_i = 1'b0;
    $display("test page control done");
    for (int i = 0; i < 10; i++) begin
      four_wire_i = t[i][24];
      acc(1'b1, 8'h00, {5'h00, t[i][22:20]});
      acc(1'b1, t[i][19:12], 8'(i + 16));
      `CHK("ext_addr", t[i][9:0], last_addr)
      rd(t[i][19:12], 8'(i + 16));
      acc(1'b1, 8'h00, 8'h00);
    end
    four_wire_i = 1'b0;
    $display("test page decode done");
    acc(1'b1, 8'h56, 8'h80);
    c = wr_cnt;
    acc(1'b1, 8'hD0, 8'h11);
    `CHK("wr_cnt", c, wr_cnt)
    acc(1'b1, 8'hCF, 8'h22);
    `CHK("wr_cnt", c + 8'h01, wr_cnt)
    acc(1'b1, 8'h56, 8'h00);
    acc(1'b1, 8'hD0, 8'h33);
    `CHK("wr_cnt", c + 8'h02, wr_cnt)
    $display("test lock done");
    cl_a = 1'b1;
    cyc(12);
    rd(8'h51, 8'hD3);
    rd(8'h53, 8'h10);
    `CHK("irq_n", 1'b0, irq_n)
    acc(1'b1, 8'h53, 8'h10);
    rd(8'h53, 8'h00);
    `CHK("irq_n", 1'b1, irq_n)
    cl_a = 1'b0;
    acc(1'b1, 8'h55, 8'h10);
    cyc(8);
    cl_a = 1'b1;
    cyc(12);
    rd(8'h53, 8'h00);
    `CHK("irq_n", 1'b1, irq_n)
    cl_a = 1'b0;
    rg_b = 1'b0;
    cyc(12);
    rd(8'h53, 8'h02);
    acc(1'b1, 8'h55, 8'h02);
    `CHK("irq_n", 1'b1, irq_n)
    rd(8'h53, 8'h02);
    acc(1'b1, 8'h53, 8'h02);
    acc(1'b1, 8'h55, 8'h00);
    {rg_b, tsd, rp_b} = 3'b111;
    cyc(12);
    rd(8'h51, 8'h4B);
    rd(8'h53, 8'h08);
    acc(1'b1, 8'h53, 8'h08);
    {uv, twn} = 2'b11;
    cyc(12);
    rd(8'h51, 8'h4F);
    rd(8'h53, 8'h04);
    acc(1'b1, 8'h53, 8'h04);
    acc(1'b1, 8'h54, 8'h40);
    `CHK("irq_n", 1'b1, irq_n)
    rd(8'h52, 8'h40);
    acc(1'b1, 8'h52, 8'h40);
    acc(1'b1, 8'h54, 8'h00);
    $display("test rail events done");
    gi = 5'h01;
    cyc(12);
    rd(8'h50, 8'h01);
    rd(8'h52, 8'h03);
    acc(1'b1, 8'h52, 8'h03);
    acc(1'b1, 8'h56, 8'h01);
    gi = 5'h05;
    cyc(2);
    gi = 5'h01;
    cyc(20);
    rd(8'h52, 8'h00);
    gi = 5'h05;
    cyc(20);
    rd(8'h52, 8'h04);
    $display("test inputs done");
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, 8'h56, {1'b0, 2'(k), 2'(k), 3'h0});
      gap(1'b0, gap_n);
      `CHK("step_a", 400 >> k, gap_n)
      gap(1'b1, gap_n);
      `CHK("step_b", 400 >> k, gap_n)
    end
    $display("test step rates done");
    close_out();
  end
endmodule
`default_nettype wire
